// [logic/cpb_bridge.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cpb_params.svh"

module cpb_bridge #(
  parameter int DEPTH      = `CPB_FIFO_DEPTH,
  parameter int WR_RETRIES = `CPB_WR_RETRIES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // CPU side single cycles
  input  wire logic        CPU_REQ,
  input  wire logic        CPU_WRITE,
  input  wire logic [31:0] CPU_ADDR,
  input  wire logic [1:0]  CPU_SIZE,
  input  wire logic [31:0] CPU_WDATA,
  output logic             CPU_ACK,
  output logic             CPU_BERR,
  output logic [31:0]      CPU_RDATA,
  // PCI initiator pins
  input  wire logic        PCI_CLK,
  input  wire logic        PCI_GNT_N,
  input  wire logic        PCI_TRDY_N,
  input  wire logic        PCI_STOP_N,
  input  wire logic        PCI_DEVSEL_N,
  input  wire logic [31:0] PCI_AD_I,
  output logic             PCI_REQ_N,
  output logic             PCI_FRAME_N_O,
  output logic             PCI_IRDY_N_O,
  output logic [3:0]       PCI_CBE_N_O,
  output logic             PCI_CTL_OE_N,
  output logic [31:0]      PCI_AD_O,
  output logic             PCI_AD_OE_N,
  // Error events
  output logic             MASTER_ERR,
  output logic             PCI_ERR_IRQ,
  // AXI4-Lite register slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [16:0] RD_LIM = 17'(`CPB_RD_RETRIES);
  localparam logic [16:0] WR_LIM = 17'(WR_RETRIES);

  // The status field is four bits wide and the write limit must exceed
  // the read limit.
  if (DEPTH < 2 || DEPTH > 15 || WR_RETRIES <= `CPB_RD_RETRIES ||
      WR_RETRIES > 131071) begin : g_bad_param
    $error("cpb_bridge: DEPTH or WR_RETRIES out of range");
  end

  // ****************************************************************
  // Registers and shared state.
  // ****************************************************************
  logic [`CPB_WIN_W-1:0] win_map_r;
  logic [`CPB_CFG_W-1:0] cfg_set_r;
  logic                  big_end_r;
  logic [1:0]            pci_stat_r;
  logic [1:0]            stat_set_r;
  logic [CW-1:0]         cnt_r;
  logic                  rd_pend_r;
  logic                  done_r;
  logic                  done_err_r;
  logic                  done_wr_r;
  logic [31:0]           done_data_r;

  // ****************************************************************
  // PCI pin synchronisers.
  // ****************************************************************
  // Inputs are held at the PCI falling edge, so the rising-edge logic
  // sees values that were stable half a PCI period earlier.
  logic [36:0] pin_s1_r;
  logic [36:0] pin_s2_r;
  logic [35:0] pin_hold_r;
  logic        pclk_d_r;
  logic        pe;
  logic        pfe;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1_r   <= 37'h0;
      pin_s2_r   <= 37'h0;
      pclk_d_r   <= 1'b0;
      pin_hold_r <= 36'hF_0000_0000;
    end else begin
      pin_s1_r <= {PCI_CLK, PCI_GNT_N, PCI_TRDY_N, PCI_STOP_N,
                   PCI_DEVSEL_N, PCI_AD_I};
      pin_s2_r <= pin_s1_r;
      pclk_d_r <= pin_s2_r[36];
      if (pfe) begin
        pin_hold_r <= pin_s2_r[35:0];
      end
    end
  end

  assign pe  = pin_s2_r[36] & ~pclk_d_r;
  assign pfe = ~pin_s2_r[36] & pclk_d_r;

  // ****************************************************************
  // CPU address decode.
  // ****************************************************************
  logic        dec_ok;
  logic [31:0] dec_addr;
  logic [3:0]  dec_cmd;
  logic [3:0]  dec_be;

  always_comb begin
    logic [7:0] be_wide;
    logic [3:0] be_le;
    logic       bad_size;
    be_wide  = 8'h00;
    be_le    = 4'h0;
    bad_size = 1'b0;
    dec_ok   = 1'b1;
    dec_addr = 32'h0;
    dec_cmd  = `CPB_CMD_MEMRD;
    // Lanes follow the access width; big-endian mirrors the lanes.
    be_wide  = 8'(8'h0F >> (2'h3 - CPU_SIZE)) << CPU_ADDR[1:0];
    be_le    = be_wide[3:0];
    dec_be   = big_end_r ? {be_le[0], be_le[1], be_le[2], be_le[3]}
                         : be_le;
    bad_size = (({1'b0, CPU_ADDR[1:0]} + {1'b0, CPU_SIZE}) > 3'h3) ||
               (CPU_SIZE == 2'h1 && CPU_ADDR[0]);
    if (CPU_ADDR[31:15] == `CPB_CFG_TOP17) begin
      dec_cmd  = `CPB_CMD_CFGRD;
      dec_ok   = (CPU_SIZE == 2'h3) && (CPU_ADDR[1:0] == 2'h0);
      dec_addr = {cfg_set_r[15:0], CPU_ADDR[15:2], 1'b0,
                  cfg_set_r[`CPB_CFG_TYPE_BIT]};
    end else if (CPU_ADDR[31:20] == `CPB_IO_TOP12) begin
      dec_cmd  = `CPB_CMD_IORD;
      dec_addr = {12'h000, CPU_ADDR[19:0]};
    end else if (CPU_ADDR[31]) begin
      dec_addr = {win_map_r[`CPB_WIN_HI_BIT], CPU_ADDR[30:0]};
    end else if (CPU_ADDR[31:26] == `CPB_LO_TOP6) begin
      dec_addr = {win_map_r[5:0], CPU_ADDR[25:0]};
    end else if (CPU_ADDR[31:26] == `CPB_LO_TOP6 + 6'h01) begin
      dec_addr = {win_map_r[11:6], CPU_ADDR[25:0]};
    end else if (CPU_ADDR[31:26] == `CPB_LO_TOP6 + 6'h02) begin
      dec_addr = {win_map_r[17:12], CPU_ADDR[25:0]};
    end else begin
      dec_ok = 1'b0;  // Includes the one-and-a-half region.
    end
    if (bad_size) begin
      dec_ok = 1'b0;
    end
  end

  // ****************************************************************
  // Posted write queue.
  // ****************************************************************
  logic [31:0]   fa_r [DEPTH];
  logic [31:0]   fd_r [DEPTH];
  logic [3:0]    fb_r [DEPTH];
  logic [3:0]    fc_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic          full;
  logic          cpu_go;
  logic          push;
  logic          pop;

  assign full   = (cnt_r == CW'(DEPTH));
  assign cpu_go = CPU_REQ & ~CPU_ACK & ~rd_pend_r;
  assign push   = cpu_go & CPU_WRITE & dec_ok & ~full;
  assign pop    = done_r & done_wr_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        fa_r[wp_r] <= dec_addr;
        fd_r[wp_r] <= CPU_WDATA;
        fb_r[wp_r] <= dec_be;
        fc_r[wp_r] <= dec_cmd | 4'h1;
        wp_r       <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + CW'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  // ****************************************************************
  // CPU handshake.
  // ****************************************************************
  logic [31:0] rd_addr_r;
  logic [3:0]  rd_cmd_r;
  logic [3:0]  rd_be_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CPU_ACK   <= 1'b0;
      CPU_BERR  <= 1'b0;
      CPU_RDATA <= 32'h0;
      rd_pend_r <= 1'b0;
      rd_addr_r <= 32'h0;
      rd_cmd_r  <= 4'h0;
      rd_be_r   <= 4'h0;
    end else begin
      CPU_ACK  <= 1'b0;
      CPU_BERR <= 1'b0;
      if (done_r && !done_wr_r) begin
        CPU_ACK   <= 1'b1;
        CPU_BERR  <= done_err_r;
        CPU_RDATA <= done_data_r;
        rd_pend_r <= 1'b0;
      end else if (cpu_go && !dec_ok) begin
        CPU_ACK  <= 1'b1;
        CPU_BERR <= 1'b1;
      end else if (push) begin
        CPU_ACK <= 1'b1;  // Released before the PCI cycle runs.
      end else if (cpu_go && !CPU_WRITE) begin
        rd_pend_r <= 1'b1;
        rd_addr_r <= dec_addr;
        rd_cmd_r  <= dec_cmd;
        rd_be_r   <= dec_be;
      end
    end
  end

  // ****************************************************************
  // PCI initiator engine, stepped once per PCI rising edge.
  // ****************************************************************
  cpb_pkg::cpb_eng_e st_r;
  cpb_pkg::cpb_res_e res_r;
  logic [31:0]       cur_addr_r;
  logic [31:0]       cur_data_r;
  logic [3:0]        cur_be_r;
  logic [3:0]        cur_cmd_r;
  logic              cur_wr_r;
  logic              addr_ph_r;
  logic [2:0]        tmr_r;
  logic [16:0]       retry_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r          <= cpb_pkg::CPB_IDLE;
      res_r         <= cpb_pkg::CPB_RES_OK;
      cur_addr_r    <= 32'h0;
      cur_data_r    <= 32'h0;
      cur_be_r      <= 4'h0;
      cur_cmd_r     <= 4'h0;
      cur_wr_r      <= 1'b0;
      addr_ph_r     <= 1'b0;
      tmr_r         <= 3'h0;
      retry_r       <= 17'h0;
      done_r        <= 1'b0;
      done_err_r    <= 1'b0;
      done_wr_r     <= 1'b0;
      done_data_r   <= 32'h0;
      stat_set_r    <= 2'h0;
      MASTER_ERR    <= 1'b0;
      PCI_ERR_IRQ   <= 1'b0;
      PCI_REQ_N     <= 1'b1;
      PCI_FRAME_N_O <= 1'b1;
      PCI_IRDY_N_O  <= 1'b1;
      PCI_CBE_N_O   <= 4'hF;
      PCI_CTL_OE_N  <= 1'b1;
      PCI_AD_O      <= 32'h0;
      PCI_AD_OE_N   <= 1'b1;
    end else begin
      done_r      <= 1'b0;
      stat_set_r  <= 2'h0;
      MASTER_ERR  <= 1'b0;
      PCI_ERR_IRQ <= 1'b0;
      if (pe) begin
        case (st_r)
          cpb_pkg::CPB_IDLE: begin
            // Queued writes go first, so a read never overtakes them.
            if (cnt_r != '0) begin
              cur_addr_r <= fa_r[rp_r];
              cur_data_r <= fd_r[rp_r];
              cur_be_r   <= fb_r[rp_r];
              cur_cmd_r  <= fc_r[rp_r];
              cur_wr_r   <= 1'b1;
              PCI_REQ_N  <= 1'b0;
              st_r       <= cpb_pkg::CPB_REQ;
            end else if (rd_pend_r) begin
              cur_addr_r <= rd_addr_r;
              cur_be_r   <= rd_be_r;
              cur_cmd_r  <= rd_cmd_r;
              cur_wr_r   <= 1'b0;
              PCI_REQ_N  <= 1'b0;
              st_r       <= cpb_pkg::CPB_REQ;
            end
          end
          cpb_pkg::CPB_REQ: begin
            if (!pin_hold_r[35]) begin
              PCI_FRAME_N_O <= 1'b0;
              PCI_CTL_OE_N  <= 1'b0;
              PCI_CBE_N_O   <= cur_cmd_r;
              PCI_AD_O      <= cur_addr_r;
              PCI_AD_OE_N   <= 1'b0;
              addr_ph_r     <= 1'b1;
              tmr_r         <= 3'h0;
              st_r          <= cpb_pkg::CPB_DATA;
            end
          end
          cpb_pkg::CPB_DATA: begin
            if (addr_ph_r) begin
              addr_ph_r     <= 1'b0;
              PCI_REQ_N     <= 1'b1;
              PCI_FRAME_N_O <= 1'b1;
              PCI_IRDY_N_O  <= 1'b0;
              PCI_CBE_N_O   <= ~cur_be_r;
              PCI_AD_O      <= cur_data_r;
              PCI_AD_OE_N   <= ~cur_wr_r;
            end else if (!pin_hold_r[34] && !pin_hold_r[32]) begin
              res_r        <= cpb_pkg::CPB_RES_OK;
              done_data_r  <= pin_hold_r[31:0];
              PCI_IRDY_N_O <= 1'b1;
              PCI_AD_OE_N  <= 1'b1;
              st_r         <= cpb_pkg::CPB_TURN;
            end else if (!pin_hold_r[33]) begin
              res_r        <= pin_hold_r[32] ? cpb_pkg::CPB_RES_TABORT
                                             : cpb_pkg::CPB_RES_RETRY;
              PCI_IRDY_N_O <= 1'b1;
              PCI_AD_OE_N  <= 1'b1;
              st_r         <= cpb_pkg::CPB_TURN;
            end else if (pin_hold_r[32] && tmr_r == `CPB_MABORT_CLKS) begin
              res_r        <= cpb_pkg::CPB_RES_MABORT;
              PCI_IRDY_N_O <= 1'b1;
              PCI_AD_OE_N  <= 1'b1;
              st_r         <= cpb_pkg::CPB_TURN;
            end else begin
              tmr_r <= tmr_r + 3'h1;
            end
          end
          cpb_pkg::CPB_TURN: begin
            PCI_CTL_OE_N <= 1'b1;
            st_r         <= cpb_pkg::CPB_IDLE;
            done_wr_r    <= cur_wr_r;
            case (res_r)
              cpb_pkg::CPB_RES_OK: begin
                done_r     <= 1'b1;
                done_err_r <= 1'b0;
                retry_r    <= 17'h0;
              end
              cpb_pkg::CPB_RES_RETRY: begin
                if (retry_r + 17'h1 >= (cur_wr_r ? WR_LIM : RD_LIM)) begin
                  done_r      <= 1'b1;
                  done_err_r  <= 1'b1;
                  PCI_ERR_IRQ <= 1'b1;  // No status bit here.
                  retry_r     <= 17'h0;
                end else begin
                  retry_r <= retry_r + 17'h1;  // Reissue same job.
                end
              end
              default: begin
                done_r     <= 1'b1;
                done_err_r <= 1'b1;
                retry_r    <= 17'h0;
                stat_set_r <= {res_r == cpb_pkg::CPB_RES_MABORT,
                               res_r == cpb_pkg::CPB_RES_TABORT};
                MASTER_ERR <= cur_wr_r;
              end
            endcase
          end
          default: begin
            st_r <= cpb_pkg::CPB_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite register slave.
  // ****************************************************************
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                  {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      win_map_r     <= `CPB_WINMAP_RST;
      cfg_set_r     <= `CPB_CFGSET_RST;
      big_end_r     <= `CPB_CTRL_RST;
      pci_stat_r    <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_r     <= S_AXI_AWADDR;
        aw_got_r      <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data_r     <= S_AXI_WDATA;
        w_strb_r     <= S_AXI_WSTRB;
        w_got_r      <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      // Hardware setting wins over a same-cycle clear.
      if (aw_got_r && w_got_r && !S_AXI_BVALID &&
          {aw_addr_r[7:2], 2'h0} == `CPB_OFF_PCISTAT) begin
        pci_stat_r <= (pci_stat_r & ~{w_data_r[`CPB_ST_MABORT_BIT] &
                                      w_strb_r[3],
                                      w_data_r[`CPB_ST_TABORT_BIT] &
                                      w_strb_r[3]}) | stat_set_r;
      end else begin
        pci_stat_r <= pci_stat_r | stat_set_r;
      end
      if (aw_got_r && w_got_r && !S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= 2'h0;
        case ({aw_addr_r[7:2], 2'h0})
          `CPB_OFF_WINMAP: begin
            win_map_r <= (win_map_r & ~wmask[`CPB_WIN_W-1:0]) |
                         (w_data_r[`CPB_WIN_W-1:0] &
                          wmask[`CPB_WIN_W-1:0]);
          end
          `CPB_OFF_CFGSET: begin
            cfg_set_r <= (cfg_set_r & ~wmask[`CPB_CFG_W-1:0]) |
                         (w_data_r[`CPB_CFG_W-1:0] &
                          wmask[`CPB_CFG_W-1:0]);
          end
          `CPB_OFF_CTRL: begin
            if (w_strb_r[0]) begin
              big_end_r <= w_data_r[`CPB_CTRL_BE_BIT];
            end
          end
          `CPB_OFF_MSTAT, `CPB_OFF_PCISTAT: begin
          end
          default: begin
            S_AXI_BRESP <= 2'h2;
          end
        endcase
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case ({S_AXI_ARADDR[7:2], 2'h0})
      `CPB_OFF_WINMAP:  rd_val = 32'(win_map_r);
      `CPB_OFF_MSTAT:   rd_val = 32'(cnt_r);  // Diag flag reads zero.
      `CPB_OFF_CFGSET:  rd_val = 32'(cfg_set_r);
      `CPB_OFF_PCISTAT: rd_val = {2'h0, pci_stat_r, 28'h0};
      `CPB_OFF_CTRL:    rd_val = 32'(big_end_r);
      default:          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= 2'h0;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RDATA   <= rd_val;
        S_AXI_RRESP   <= rd_hit ? 2'h0 : 2'h2;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_ARREADY <= 1'b0;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

endmodule : cpb_bridge

`default_nettype wire

// [logic/cpb_params.svh]
`ifndef CPB_PARAMS_SVH
`define CPB_PARAMS_SVH

// ****************************************************************
// Register offsets on the AXI4-Lite slave (byte addresses).
// ****************************************************************
`define CPB_OFF_WINMAP    8'h00
`define CPB_OFF_MSTAT     8'h04
`define CPB_OFF_CFGSET    8'h08
`define CPB_OFF_PCISTAT   8'h0C
`define CPB_OFF_CTRL      8'h10

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CPB_WIN_HI_BIT    18
`define CPB_WIN_W         19
`define CPB_CFG_TYPE_BIT  16
`define CPB_CFG_W         17
`define CPB_ST_MABORT_BIT 29
`define CPB_ST_TABORT_BIT 28
`define CPB_DIAG_BIT      5
`define CPB_CTRL_BE_BIT   0
`define CPB_WINMAP_RST    19'h00000
`define CPB_CFGSET_RST    17'h00000
`define CPB_CTRL_RST      1'b0

// ****************************************************************
// CPU physical address regions.
// ****************************************************************
`define CPB_CFG_TOP17     17'h003FD
`define CPB_IO_TOP12      12'h1FD
`define CPB_LO_TOP6       6'h04
`define CPB_P15_TOP6      6'h07

// ****************************************************************
// PCI bus commands, reads only; a write sets bit 0.
// ****************************************************************
`define CPB_CMD_IORD      4'h2
`define CPB_CMD_MEMRD     4'h6
`define CPB_CMD_CFGRD     4'hA

// ****************************************************************
// Timing, retry counts and queue depth.
// ****************************************************************
`define CPB_MABORT_CLKS   3'h5
`define CPB_RD_RETRIES    256
`define CPB_WR_RETRIES    65536
`define CPB_FIFO_DEPTH    4

`endif

// [logic/cpb_pkg.sv]
package cpb_pkg;

  typedef enum logic [3:0] {
    CPB_IDLE = 4'h1,
    CPB_REQ  = 4'h2,
    CPB_DATA = 4'h4,
    CPB_TURN = 4'h8
  } cpb_eng_e;

  typedef enum logic [3:0] {
    CPB_RES_OK     = 4'h1,
    CPB_RES_RETRY  = 4'h2,
    CPB_RES_TABORT = 4'h4,
    CPB_RES_MABORT = 4'h8
  } cpb_res_e;

endpackage : cpb_pkg

// [testbench/cpb_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Port checker.
// ****************************************************************
module cpb_chk (
  // Clock, reset and events
  input wire logic CLK, RST_N, CPU_ACK, CPU_BERR, MASTER_ERR, PCI_ERR_IRQ,
  // Register bus
  input wire logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
  input wire logic S_AXI_BVALID, S_AXI_BREADY,
  // PCI controls
  input wire logic PCI_FRAME_N_O, PCI_IRDY_N_O, PCI_CTL_OE_N, PCI_AD_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_berr; CPU_BERR |-> CPU_ACK; endproperty
  a_berr: assert property (p_berr) else $error("berr alone");
  property p_ack; CPU_ACK |=> !CPU_ACK; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_merr; MASTER_ERR |=> !MASTER_ERR; endproperty
  a_merr: assert property (p_merr) else $error("merr too long");
  property p_irq; PCI_ERR_IRQ |-> !MASTER_ERR ##1 !PCI_ERR_IRQ; endproperty
  a_irq: assert property (p_irq) else $error("bad irq pulse");
  property p_ar; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_ar: assert property (p_ar) else $error("late read data");
  property p_bv; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
  a_bv: assert property (p_bv) else $error("bvalid dropped");
  property p_adr;
    !PCI_FRAME_N_O && !PCI_CTL_OE_N |-> !PCI_AD_OE_N && PCI_IRDY_N_O;
  endproperty
  a_adr: assert property (p_adr) else $error("bad addr phase");
  property p_dat; !PCI_IRDY_N_O && !PCI_CTL_OE_N |-> PCI_FRAME_N_O; endproperty
  a_dat: assert property (p_dat) else $error("burst seen");
endmodule : cpb_chk
bind cpb_bridge cpb_chk u_chk (.*);
`default_nettype wire

// [testbench/cpb_pci_tgt.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// PCI target model; mode 0 ok, 1 retry, 2 abort, 3 silent.
// ****************************************************************
module cpb_pci_tgt (
  // Bus seen by the target
  input  wire logic        pci_clk, req_n, frame_n, irdy_n,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [31:0] ad_o,
  input  wire logic [1:0]  mode,
  output logic             gnt_n, trdy_n, stop_n, devsel_n,
  output logic [31:0]      ad_i
);
  logic [31:0] adr_r, dat_r;
  logic [3:0]  cmd_r, be_r;
  int          n_r = 0;
  initial {gnt_n, trdy_n, stop_n, devsel_n, ad_i} = {4'hF, 32'h0};
  always @(posedge pci_clk) begin
    gnt_n <= req_n;
    if (!frame_n) begin
      adr_r <= ad_o;
      cmd_r <= cbe_n;
      n_r <= n_r + 1;
      devsel_n <= mode[1];
      trdy_n <= mode != 2'h0;
      stop_n <= mode == 2'h0 || mode == 2'h3;
      ad_i <= {ad_o[15:0], ad_o[31:16]};
    end else if (!irdy_n) begin
      be_r <= cbe_n;
      dat_r <= ad_o;
    end else begin
      // Released lines float high; data lines toggle so no stale value.
      {trdy_n, stop_n, devsel_n} <= 3'h7;
      ad_i <= ~ad_i;
    end
  end
endmodule : cpb_pci_tgt
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Bench top.
// ****************************************************************
module testbench;
  logic CLK = 0, RST_N = 0, PCI_CLK = 0, CPU_REQ = 0, CPU_WRITE = 0, be;
  logic [31:0] CPU_ADDR = 0, CPU_WDATA = 0, S_AXI_WDATA = 0, PCI_AD_I;
  logic [31:0] PCI_AD_O, CPU_RDATA, S_AXI_RDATA, rd, cr, m, c, a;
  logic [1:0] CPU_SIZE = 0, S_AXI_BRESP, S_AXI_RRESP, mode = 0, rr;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [3:0] S_AXI_WSTRB = 4'hF, PCI_CBE_N_O, ec, eb;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, merr = 0, irq = 0, bg = 0;
  logic CPU_ACK, CPU_BERR, PCI_GNT_N, PCI_TRDY_N, PCI_STOP_N, PCI_DEVSEL_N;
  logic PCI_REQ_N, PCI_FRAME_N_O, PCI_IRDY_N_O, PCI_CTL_OE_N, PCI_AD_OE_N;
  logic MASTER_ERR, PCI_ERR_IRQ, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  int errors = 0, n_tests = 0, k, i, n0, j;
  always #2 CLK = ~CLK;
  initial #37 forever #80 PCI_CLK = ~PCI_CLK;
  always @(posedge CLK) begin
    if (MASTER_ERR === 1'b1) merr <= 1;
    if (PCI_ERR_IRQ === 1'b1) irq <= 1;
  end
  cpb_bridge #(.WR_RETRIES(300)) dut (.*);
  cpb_pci_tgt pt (.pci_clk(PCI_CLK), .req_n(PCI_REQ_N), .mode(mode),
    .frame_n(PCI_FRAME_N_O | PCI_CTL_OE_N), .cbe_n(PCI_CBE_N_O),
    .irdy_n(PCI_IRDY_N_O | PCI_CTL_OE_N), .ad_o(PCI_AD_O), .ad_i(PCI_AD_I),
    .gnt_n(PCI_GNT_N), .trdy_n(PCI_TRDY_N), .stop_n(PCI_STOP_N),
    .devsel_n(PCI_DEVSEL_N));
  task wrap_up;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task tmo(input int lim);
    if (k >= lim) begin
      errors++;
      wrap_up;
    end
  endtask : tmo
  task aw(input logic [7:0] ad, input logic [31:0] d);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {ad, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while (S_AXI_BVALID !== 1'b1 && k < 99);
    {S_AXI_BREADY, rr} <= {1'b0, S_AXI_BRESP};
    tmo(99);
    @(posedge CLK);
  endtask : aw
  task ar(input logic [7:0] ad);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {ad, 2'h3};
    k = 0;
    do begin
      @(posedge CLK);
      k++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end while (S_AXI_RVALID !== 1'b1 && k < 99);
    {S_AXI_RREADY, rd, rr} <= {1'b0, S_AXI_RDATA, S_AXI_RRESP};
    tmo(99);
    @(posedge CLK);
  endtask : ar
  // Polls one register until the masked value appears; the bound is a
  // mismatch of its own, since the per-read counter restarts each call.
  task poll(input logic [7:0] ad, input logic [31:0] msk, val);
    j = 0;
    do begin
      ar(ad);
      j++;
    end while ((rd & msk) !== val && j < 999);
    k = j;
    tmo(999);
  endtask : poll
  task cpu(input logic w, input logic [31:0] ad, d, input logic [1:0] s);
    n0 = pt.n_r;
    {CPU_REQ, CPU_WRITE, CPU_ADDR, CPU_WDATA, CPU_SIZE} <= {1'b1, w, ad, d, s};
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (CPU_ACK !== 1'b1 && k < 90000);
    CPU_REQ <= 1'b0;
    {be, cr} = {CPU_BERR, CPU_RDATA};
    tmo(90000);
    @(posedge CLK);
  endtask : cpu
  function logic [31:0] pa(input logic [31:0] ad);
    if (ad[31]) return {m[18], ad[30:0]};
    if (ad[31:20] == 12'h1FD) return {12'h0, ad[19:0]};
    if (ad[31:16] == 16'h01FE) return {c[15:0], ad[15:2], 1'b0, c[16]};
    return {m[ad[27:26] * 6 +: 6], ad[25:0]};
  endfunction : pa
  task xfer(input logic w, input logic [31:0] ad, d, input logic [1:0] s);
    ec = ad[31:20] == 12'h1FD ? 4'h2 : ad[31:16] == 16'h01FE ? 4'hA : 4'h6;
    eb = 4'((5'h2 << s) - 1) << ad[1:0];
    if (bg) eb = {eb[0], eb[1], eb[2], eb[3]};
    eb = ~eb;
    a = pa(ad);
    cpu(w, ad, d, s);
    if (w) begin
      chk(pt.n_r, n0);
      ar(8'h04);
      chk(rd[3:0], 1);
      poll(8'h04, 32'hF, 0);
      chk(pt.dat_r, d);
    end else chk(cr, {a[15:0], a[31:16]});
    chk(pt.adr_r, a);
    chk(pt.cmd_r, ec | w);
    chk(pt.be_r, eb);
  endtask : xfer
  initial begin
    k = $urandom(98);
    m = $urandom & 32'h7FFFF;
    c = $urandom & 32'h1FFFF;
    repeat (8) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    ar(8'h04);
    chk(rd, 0);
    aw(8'h00, m);
    aw(8'h08, c);
    ar(8'h00);
    chk(rd, m);
    ar(8'h44);
    chk(rr, 2'h2);
    aw(8'h44, 0);
    chk(rr, 2'h2);
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      a = $urandom & 32'h03FFFFFC;
      xfer(1, 32'h1000_0000 + (i << 26) + a, $urandom, 3);
    end
    xfer(0, 32'h8000_0001 + ($urandom & 32'h7FFFFFF0), 0, 0);
    xfer(0, 32'h01FE_8000 + ($urandom & 32'h7FFC), 0, 3);
    xfer(1, 32'h1FD0_0002 + ($urandom & 32'hFFFFC), $urandom, 1);
    aw(8'h10, 1);
    bg = 1;
    xfer(1, 32'h1400_0001, $urandom, 0);
    $display("test mapping done");
    for (i = 0; i < 4; i++) cpu(1, 32'h1000_0000, i, 3);
    ar(8'h04);
    chk(rd[3:0], 4);
    cpu(1, 32'h1000_0000, 4, 3);
    chk(k > 20, 1);
    poll(8'h04, 32'hF, 0);
    chk(pt.dat_r, 4);
    $display("test queue done");
    cpu(0, 32'h1C00_0000, 0, 3);
    chk({be, pt.n_r == n0}, 2'h3);
    mode <= 3;
    cpu(0, 32'h8000_0000, 0, 3);
    ar(8'h0C);
    chk({be, rd[29], merr}, 3'h6);
    mode <= 2;
    cpu(1, 32'h1000_0000, 0, 3);
    poll(8'h0C, 32'h1000_0000, 32'h1000_0000);
    chk(merr, 1);
    aw(8'h0C, 32'h3000_0000);
    mode <= 1;
    cpu(0, 32'h8000_0000, 0, 3);
    chk(pt.n_r - n0, 256);
    ar(8'h0C);
    chk({be, irq, rd[29:28]}, 4'hC);
    $display("test errors done");
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
